// ### hw/pmc_misc_bus_config.sv
// Misc bus configuration register: APB slave, capability copies, clock gate overrides and clock keep-alive.
`default_nettype none

// Summary of operation
// - Reserved bits 31-16, 14, 12-11, 9-3 read zero; writes there ignored.
// - Bit 15 drives the cold-off wake capability bit in the capabilities register.
// - Bits 15, 13, 10 survive bus reset and D3 to D0 transitions.
// - Bit 13 drives light-sleep wake capability; cleared means unsupported.
// - Bit 10 drives light-sleep state capability; cleared means state unsupported.
// - Bit 2 set stops gating of the internal link clock.
// - Bit 1 set stops gating of the internal bus clock.
// - Bit 0 set keeps the bus clock running through the clock-run protocol.
// - Bit 0 clear lets the system stop the bus clock.
module pmc_misc_bus_config
  import pmc_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  input  wire logic              bus_reset_input_n,
  input  wire logic [1:0]        power_state,
  input  wire logic              link_idle,
  input  wire logic              bus_idle,
  input  wire logic              clock_stop_request,
  output logic                   wake_from_cold_off_cap,
  output logic                   wake_from_light_sleep_cap,
  output logic                   light_sleep_state_cap,
  output logic                   link_clock_gate_override,
  output logic                   bus_clock_gate_override,
  output logic                   keep_bus_clock,
  output logic                   link_clock_stop,
  output logic                   bus_clock_stop,
  output logic                   bus_clock_stop_allow
);

  // Transfer sequencing and the registered answer to the host.
  pmc_apb_state_t state_q;
  pmc_apb_state_t state_d;
  logic           pready_q;
  logic           pready_d;
  logic [31:0]    prdata_q;
  logic [31:0]    prdata_d;
  logic           pslverr_q;
  logic           pslverr_d;

  // Stored configuration, one flip-flop per bit position.
  logic [31:0]    cfg_q;
  logic [31:0]    cfg_d;

  // Power state seen at the previous edge, to spot the D3 to D0 step.
  logic [1:0]     pwr_prev_q;
  logic [1:0]     pwr_prev_d;

  // Requests towards the clock gating and clock-run logic.
  logic           link_stop_q;
  logic           link_stop_d;
  logic           bus_stop_q;
  logic           bus_stop_d;
  logic           stop_allow_q;
  logic           stop_allow_d;

  // Bus decode.
  wire            setup_cyc;
  wire            access_cyc;
  wire            addr_hit;
  wire            wr_commit;
  wire            rd_access;
  wire            err_access;
  wire     [31:0] lane_mask;
  wire     [31:0] wr_mask;
  wire     [31:0] rd_value;

  // Soft resets and sticky positions.
  wire            d3_to_d0;
  wire            soft_rst;
  wire     [31:0] sticky_msk;

  // Stored fields by name.
  wire            cold_off_bit;
  wire            light_wake_bit;
  wire            light_state_bit;
  wire            link_override_bit;
  wire            bus_override_bit;
  wire            keep_clock_bit;

  // Gating permissions.
  wire            link_gate_ok;
  wire            bus_gate_ok;
  wire            clock_stop_ok;

  assign setup_cyc  = psel && !penable;
  assign access_cyc = psel && penable && (state_q == PMC_ACCESS);
  assign addr_hit   = (paddr[ADDR_W-1:2] == MISC_BUS_CONFIG_OFFSET[ADDR_W-1:2]);
  // The write lands at the edge where pready is high, never earlier.
  assign wr_commit  = psel && penable && pready_q && pwrite && addr_hit;
  assign rd_access  = access_cyc && !pwrite && addr_hit;
  assign err_access = access_cyc && !addr_hit;

  // Byte lanes: each strobe enables its eight data bits.
  genvar lane_idx;
  generate
    for (lane_idx = 0; lane_idx < 4; lane_idx++) begin : g_lane
      assign lane_mask[lane_idx*8 +: 8] = {8{pstrb[lane_idx]}};
    end
  endgenerate

  assign wr_mask    = lane_mask & MISC_BUS_CONFIG_WMASK;
  // Reserved positions are never stored, so masking the read is a second guard only.
  assign rd_value   = cfg_q & MISC_BUS_CONFIG_WMASK;

  // A return from D3 to D0 clears the volatile bits the same way a bus reset does.
  // The power state is compared edge to edge, so a step through D1 or D2 is not seen.
  assign d3_to_d0   = (pwr_prev_q == PWR_STATE_D3) && (power_state == PWR_STATE_D0);
  assign soft_rst   = !bus_reset_input_n || d3_to_d0;
  assign sticky_msk = (32'h0000_0001 << WAKE_FROM_COLD_OFF_BIT)
                    | (32'h0000_0001 << WAKE_FROM_LIGHT_SLEEP_BIT)
                    | (32'h0000_0001 << LIGHT_SLEEP_STATE_BIT);

  assign cold_off_bit      = cfg_q[WAKE_FROM_COLD_OFF_BIT];
  assign light_wake_bit    = cfg_q[WAKE_FROM_LIGHT_SLEEP_BIT];
  assign light_state_bit   = cfg_q[LIGHT_SLEEP_STATE_BIT];
  assign link_override_bit = cfg_q[LINK_CLOCK_GATE_OVERRIDE_BIT];
  assign bus_override_bit  = cfg_q[BUS_CLOCK_GATE_OVERRIDE_BIT];
  assign keep_clock_bit    = cfg_q[KEEP_BUS_CLOCK_BIT];

  assign link_gate_ok  = !link_override_bit;
  assign bus_gate_ok   = !bus_override_bit;
  assign clock_stop_ok = !keep_clock_bit;

  // One loop for every bit position: reserved bits stay zero, sticky bits
  // ignore soft resets, volatile bits return to their reset value.
  genvar bit_idx;
  generate
    for (bit_idx = 0; bit_idx < 32; bit_idx++) begin : g_cfg_bit
      wire bit_writable;
      wire bit_sticky;
      wire bit_write;
      wire bit_merged;
      wire bit_volatile_rst;

      assign bit_writable     = MISC_BUS_CONFIG_WMASK[bit_idx];
      assign bit_sticky       = sticky_msk[bit_idx];
      assign bit_write        = wr_commit && wr_mask[bit_idx];
      assign bit_merged       = bit_write ? pwdata[bit_idx] : cfg_q[bit_idx];
      // A soft reset in the same cycle as a write wins for the volatile bits.
      assign bit_volatile_rst = soft_rst && !bit_sticky;

      assign cfg_d[bit_idx] = !bit_writable    ? 1'b0
                            : bit_volatile_rst ? MISC_BUS_CONFIG_RESET[bit_idx]
                            : bit_merged;

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cfg_q[bit_idx] <= MISC_BUS_CONFIG_RESET[bit_idx];
        end else begin
          cfg_q[bit_idx] <= cfg_d[bit_idx];
        end
      end
    end
  endgenerate

  // One wait state: the answer is registered so every bus output comes from a flip-flop.
  // Timing of one transfer, counted in cycles:
  //   c0  setup, psel high and penable low;
  //   c1  access, penable high, the answer is prepared;
  //   c2  pready high with read data or the error flag;
  //   the write lands at the edge that ends c2.
  // The cost is a fixed wait state on every transfer, which a
  // configuration register can easily afford.
  always_comb begin
    state_d = state_q;
    case (state_q)
      PMC_IDLE: begin
        if (setup_cyc) begin
          state_d = PMC_ACCESS;
        end else begin
          state_d = PMC_IDLE;
        end
      end
      PMC_ACCESS: begin
        if (access_cyc) begin
          state_d = PMC_DONE;
        end else if (psel) begin
          state_d = PMC_ACCESS;
        end else begin
          state_d = PMC_IDLE;
        end
      end
      PMC_DONE: begin
        if (setup_cyc) begin
          state_d = PMC_ACCESS;
        end else begin
          state_d = PMC_IDLE;
        end
      end
      default: begin
        state_d = PMC_IDLE;
      end
    endcase
  end

  // The answer stands for exactly the one cycle in which pready is high.
  assign pready_d     = (state_d == PMC_DONE);
  assign prdata_d     = rd_access ? rd_value : 32'h0000_0000;
  assign pslverr_d    = err_access;
  assign pwr_prev_d   = power_state;
  assign link_stop_d  = link_idle && link_gate_ok;
  assign bus_stop_d   = bus_idle && bus_gate_ok;
  assign stop_allow_d = clock_stop_request && clock_stop_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= PMC_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= pready_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else begin
      prdata_q <= prdata_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_q <= 1'b0;
    end else begin
      pslverr_q <= pslverr_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_prev_q <= PWR_STATE_D0;
    end else begin
      pwr_prev_q <= pwr_prev_d;
    end
  end

  // Registering the stop requests costs a cycle of latency but keeps
  // decode glitches away from the clock gating cells.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_stop_q <= 1'b0;
    end else begin
      link_stop_q <= link_stop_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_stop_q <= 1'b0;
    end else begin
      bus_stop_q <= bus_stop_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_allow_q <= 1'b0;
    end else begin
      stop_allow_q <= stop_allow_d;
    end
  end

  // Every output below is a flip-flop or a single stored bit.
  assign pready                    = pready_q;
  assign prdata                    = prdata_q;
  assign pslverr                   = pslverr_q;
  assign wake_from_cold_off_cap    = cold_off_bit;
  assign wake_from_light_sleep_cap = light_wake_bit;
  assign light_sleep_state_cap     = light_state_bit;
  assign link_clock_gate_override  = link_override_bit;
  assign bus_clock_gate_override   = bus_override_bit;
  assign keep_bus_clock            = keep_clock_bit;
  assign link_clock_stop           = link_stop_q;
  assign bus_clock_stop            = bus_stop_q;
  assign bus_clock_stop_allow      = stop_allow_q;

endmodule
`default_nettype wire

// ### hw/pmc_pkg.sv
// Package with the address map, field positions and reset value of the misc bus configuration register.
`default_nettype none
package pmc_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam logic [ADDR_W-1:0] MISC_BUS_CONFIG_OFFSET = 12'h0F0;
  localparam logic [31:0] MISC_BUS_CONFIG_RESET = 32'h0000_2400;
  localparam logic [31:0] MISC_BUS_CONFIG_WMASK = 32'h0000_A407;
  localparam int unsigned WAKE_FROM_COLD_OFF_BIT = 15;
  localparam int unsigned WAKE_FROM_LIGHT_SLEEP_BIT = 13;
  localparam int unsigned LIGHT_SLEEP_STATE_BIT = 10;
  localparam int unsigned LINK_CLOCK_GATE_OVERRIDE_BIT = 2;
  localparam int unsigned BUS_CLOCK_GATE_OVERRIDE_BIT = 1;
  localparam int unsigned KEEP_BUS_CLOCK_BIT = 0;
  localparam logic [1:0] PWR_STATE_D0 = 2'h0;
  localparam logic [1:0] PWR_STATE_D3 = 2'h3;
  typedef enum logic [1:0] {
    PMC_IDLE,
    PMC_ACCESS,
    PMC_DONE
  } pmc_apb_state_t;
endpackage
`default_nettype wire

// ### verification/pmc_misc_bus_config_properties.sv
// Checker for the misc bus configuration register.
`default_nettype none
module pmc_misc_bus_config_properties (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  input wire logic        wake_from_cold_off_cap,
  input wire logic        wake_from_light_sleep_cap,
  input wire logic        light_sleep_state_cap,
  input wire logic        link_clock_gate_override,
  input wire logic        bus_clock_gate_override,
  input wire logic        keep_bus_clock,
  input wire logic        link_clock_stop,
  input wire logic        bus_clock_stop,
  input wire logic        bus_clock_stop_allow
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire rd = pready && !pwrite && !pslverr;
  chk_rsvd_zero: assert property (rd |-> (prdata & 32'hFFFF_5BF8) == '0) else $error("rsvd read");
  chk_link_read: assert property (rd |-> prdata[2] == link_clock_gate_override) else $error("bit2 read");
  chk_bus_read: assert property (rd |-> prdata[1] == bus_clock_gate_override) else $error("bit1 read");
  chk_keep_read: assert property (rd |-> prdata[0] == keep_bus_clock) else $error("bit0 read");
  chk_link_gate: assert property (link_clock_gate_override |=> !link_clock_stop) else $error("link gated");
  chk_bus_gate: assert property (bus_clock_gate_override |=> !bus_clock_stop) else $error("bus gated");
  chk_keep_clk: assert property (keep_bus_clock |=> !bus_clock_stop_allow) else $error("stop allowed");
  chk_err_zero: assert property (pready && pslverr |-> prdata == '0) else $error("unmapped data");
  chk_cold_read: assert property (rd |-> prdata[15] == wake_from_cold_off_cap) else $error("bit15 read");
  chk_wake_read: assert property (rd |-> prdata[13] == wake_from_light_sleep_cap) else $error("bit13 read");
  chk_state_read: assert property (rd |-> prdata[10] == light_sleep_state_cap) else $error("bit10 read");
  chk_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
endmodule
bind pmc_misc_bus_config pmc_misc_bus_config_properties u_props (.pclk, .presetn, .pwrite, .pready, .pslverr,
  .prdata, .wake_from_cold_off_cap, .wake_from_light_sleep_cap, .light_sleep_state_cap,
  .link_clock_gate_override, .bus_clock_gate_override, .keep_bus_clock, .link_clock_stop,
  .bus_clock_stop, .bus_clock_stop_allow);
`default_nettype wire

// ### verification/pmc_host.sv
// Host model: APB master issuing configuration reads and writes.
`default_nettype none
module pmc_host (
  input wire logic        pclk,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, hung = 1'b0, rerr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rdata;
  logic [3:0]  pstrb = 4'hF;
  // The wait is bounded so that a silent slave cannot hang the run.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge pclk);
    if (n == 20) hung = 1'b1;
    rdata = prdata;
    rerr = pslverr;
    {psel, penable} <= 2'b00;
    // One idle edge keeps a following call from re-driving psel in the same time step.
    @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// ### verification/pmc_misc_bus_config_tb_top.sv
// Bench for the misc bus configuration register.
`default_nettype none
module pmc_misc_bus_config_tb_top import pmc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic             pclk = 1'b0, presetn = 1'b0, br_n = 1'b1, idle = 1'b0;
  logic [1:0]       ps = PWR_STATE_D0;
  wire logic        pready;
  wire logic        pslverr;
  wire logic [31:0] prdata;
  wire logic [8:0]  o;
  int               err_count = 0, n_tests = 0;
  pmc_host h (.pclk, .pready, .prdata, .pslverr);
  pmc_misc_bus_config DUT (.pclk, .presetn, .psel(h.psel), .penable(h.penable), .pwrite(h.pwrite), .paddr(h.paddr),
    .pwdata(h.pwdata), .pstrb(h.pstrb), .pready, .prdata, .pslverr, .bus_reset_input_n(br_n), .power_state(ps),
    .link_idle(idle), .bus_idle(idle), .clock_stop_request(idle), .wake_from_cold_off_cap(o[8]),
    .wake_from_light_sleep_cap(o[7]), .light_sleep_state_cap(o[6]), .link_clock_gate_override(o[5]),
    .bus_clock_gate_override(o[4]), .keep_bus_clock(o[3]), .link_clock_stop(o[2]), .bus_clock_stop(o[1]),
    .bus_clock_stop_allow(o[0]));
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp || h.hung) begin
      err_count++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
    if (h.hung) summarize();
  endtask
  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] exp);
    h.xfer(1'b0, a, 32'h0);
    chk(nm, exp, h.rdata);
  endtask
  task automatic t_mask();
    h.xfer(1'b1, 12'h0F0, 32'hFFFF_FFFF);
    rd("unmapped", 12'h0F4, 32'h0);
    chk("unmapped err", 32'h0000_0001, 32'(h.rerr));
    rd("mask", 12'h0F0, 32'h0000_A407);
    chk("mapped err", 32'h0000_0000, 32'(h.rerr));
    chk("pins", 32'h0000_01F8, 32'(o));
  endtask
  task automatic t_sticky();
    br_n <= 1'b0;
    @(posedge pclk);
    br_n <= 1'b1;
    rd("bus reset", 12'h0F0, 32'h0000_A400);
    h.xfer(1'b1, 12'h0F0, 32'h0000_A407);
    ps <= PWR_STATE_D3;
    @(posedge pclk);
    ps <= PWR_STATE_D0;
    @(posedge pclk);
    rd("d3 to d0", 12'h0F0, 32'h0000_A400);
  endtask
  task automatic t_clock();
    idle <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("stops", 32'h0000_0007, 32'(o[2:0]));
    h.xfer(1'b1, 12'h0F0, 32'h0000_0007);
    repeat (3) @(posedge pclk);
    chk("overrides", 32'h0000_0038, 32'(o));
    h.xfer(1'b1, 12'h0F0, 32'h0000_0000);
    repeat (3) @(posedge pclk);
    chk("cleared", 32'h0000_0007, 32'(o));
  endtask
  task automatic summarize();
    $display("tests %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial forever #5 pclk = ~pclk;
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd("reset", 12'h0F0, 32'h0000_2400);
    t_mask();
    t_sticky();
    t_clock();
    summarize();
  end
endmodule
`default_nettype wire
